// ---- src/afc_pkg.sv ----
// Shared constants and types for the asynchronous flash bus cycle sequencer.
package afc_pkg;
   // ****************************************************************
   // Register map and field layout
   // ****************************************************************
   localparam logic [7:0] CFG_OFF       = 8'h00;
   localparam logic [7:0] STAT_OFF      = 8'h04;
   localparam int         WAIT_LSB      = 0;
   localparam int         MASK_BIT      = 4;
   localparam int         SETUP_LSB     = 8;
   localparam int         HOLD_LSB      = 12;
   localparam int         WR_ANY_LSB    = 16;
   localparam int         RW_SAME_LSB   = 20;
   localparam int         RW_OTHER_LSB  = 24;
   // ****************************************************************
   // Values after reset
   // ****************************************************************
   localparam logic [3:0] WAIT_RST      = 4'h4;
   localparam logic       MASK_RST      = 1'b1;
   localparam logic [1:0] SETUP_RST     = 2'h1;
   localparam logic [1:0] HOLD_RST      = 2'h1;
   localparam logic [2:0] IDLE_RST      = 3'h1;
   // Cycles from the last bus cycle to the read answer (two sync stages).
   localparam int         RD_LAT        = 3;
   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic [2:0] rw_other;
      logic [2:0] rw_same;
      logic [2:0] wr_any;
      logic [1:0] hold;
      logic [1:0] setup;
      logic       mask;
      logic [3:0] wait_cnt;
   } afc_cfg_type;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SETUP = 3'b001,
      ST_FIRST = 3'b010,
      ST_WAIT  = 3'b011,
      ST_LAST  = 3'b100,
      ST_HOLD  = 3'b101,
      ST_GAP   = 3'b110
   } afc_state_type;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        other_area;
      logic [21:0] addr;
      logic [15:0] wdata;
   } afc_req_type;
   typedef struct packed {
      logic        area0_select_n;
      logic        read_strobe_n;
      logic        write_strobe_n;
      logic        data_oe;
      logic [21:0] addr;
      logic [15:0] dout;
   } afc_pins_type;
endpackage : afc_pkg

// ---- src/afc_regs.sv ----
// APB register slave holding the bus timing configuration and status.
`timescale 1ns/100ps
`default_nettype none
module afc_regs (
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire logic [7:0]           paddr,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic [7:0]           status,
   output afc_pkg::afc_cfg_type      cfg
);
   typedef struct packed {
      afc_pkg::afc_cfg_type cfg;
      logic [31:0]          rdata;
      logic                 ready;
      logic                 err;
   } afc_regs_state_type;

   afc_regs_state_type s;
   afc_regs_state_type next_s;
   logic               hit_cfg;
   logic               hit_stat;

   assign hit_cfg  = paddr == afc_pkg::CFG_OFF;
   assign hit_stat = paddr == afc_pkg::STAT_OFF;

   always_comb begin
      next_s       = s;
      // Answer one cycle into the access phase: data and error are set up
      // during the setup cycle so they come from flip-flops.
      next_s.ready = psel && !penable;
      if (psel && !penable) begin
         next_s.err   = !(hit_cfg || hit_stat);
         next_s.rdata = 32'h0;
         if (hit_cfg) begin
            next_s.rdata[afc_pkg::WAIT_LSB +: 4]     = s.cfg.wait_cnt;
            next_s.rdata[afc_pkg::MASK_BIT]          = s.cfg.mask;
            next_s.rdata[afc_pkg::SETUP_LSB +: 2]    = s.cfg.setup;
            next_s.rdata[afc_pkg::HOLD_LSB +: 2]     = s.cfg.hold;
            next_s.rdata[afc_pkg::WR_ANY_LSB +: 3]   = s.cfg.wr_any;
            next_s.rdata[afc_pkg::RW_SAME_LSB +: 3]  = s.cfg.rw_same;
            next_s.rdata[afc_pkg::RW_OTHER_LSB +: 3] = s.cfg.rw_other;
         end else if (hit_stat) begin
            next_s.rdata[7:0] = status;
         end
      end
      if (psel && penable && s.ready && pwrite && hit_cfg) begin
         next_s.cfg.wait_cnt = pwdata[afc_pkg::WAIT_LSB +: 4];
         next_s.cfg.mask     = pwdata[afc_pkg::MASK_BIT];
         next_s.cfg.setup    = pwdata[afc_pkg::SETUP_LSB +: 2];
         next_s.cfg.hold     = pwdata[afc_pkg::HOLD_LSB +: 2];
         next_s.cfg.wr_any   = pwdata[afc_pkg::WR_ANY_LSB +: 3];
         next_s.cfg.rw_same  = pwdata[afc_pkg::RW_SAME_LSB +: 3];
         next_s.cfg.rw_other = pwdata[afc_pkg::RW_OTHER_LSB +: 3];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s.cfg.wait_cnt <= afc_pkg::WAIT_RST;
         s.cfg.mask     <= afc_pkg::MASK_RST;
         s.cfg.setup    <= afc_pkg::SETUP_RST;
         s.cfg.hold     <= afc_pkg::HOLD_RST;
         s.cfg.wr_any   <= afc_pkg::IDLE_RST;
         s.cfg.rw_same  <= afc_pkg::IDLE_RST;
         s.cfg.rw_other <= afc_pkg::IDLE_RST;
         s.rdata        <= 32'h0;
         s.ready        <= 1'b0;
         s.err          <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   assign cfg     = s.cfg;
   assign prdata  = s.rdata;
   assign pready  = s.ready;
   assign pslverr = s.err;
endmodule : afc_regs
`default_nettype wire

// ---- src/afc_seq.sv ----
// Access cycle sequencer for one select area of an asynchronous flash bus.
//
// Operation
// - Wait states are inserted between the first and the last bus cycle, four by default.
// - Address and area select lead the strobe by the setup interval, one clock by default.
// - Address and area select stay asserted for the hold interval after the strobe ends.
// - Idle cycles separate write-any, read-write same area and read-write other area pairs.
// - The read strobe is released before the area select at the end of a read; with hold code 0 both are released together.
// - Write data are driven only after idle spacing that lets the memory release the bus.
// - Setup and hold codes 0..3 mean 0.5..3.5 clocks, i.e. 0..3 whole cycles here.
// - The wait field is four bits; code 4'h4 gives four wait states.
// - With the external wait mask set, the wait input is ignored.
// - Each idle field is three bits; code 3'h1 gives one idle cycle.
`timescale 1ns/100ps
`default_nettype none
module afc_seq (
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire logic [7:0]           paddr,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire afc_pkg::afc_req_type req,
   output logic                      req_ready,
   output logic                      rsp_valid,
   output logic      [15:0]          rsp_rdata,
   output afc_pkg::afc_pins_type     mem,
   input  wire logic [15:0]          data_in,
   input  wire logic                 ext_wait_n
);
   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      afc_pkg::afc_state_type st;
      afc_pkg::afc_req_type   cur;
      afc_pkg::afc_pins_type  pins;
      logic [3:0]             cnt;
      logic [2:0]             idle_cnt;
      logic                   prev_valid;
      logic                   prev_write;
      logic                   prev_other;
      logic [15:0]            din1;
      logic [15:0]            din2;
      logic                   wait1;
      logic                   wait2;
      logic [1:0]             rd_pipe;
      logic                   ready;
      logic                   rsp;
      logic [15:0]            rdata;
      logic [4:0]             a_lo;
      logic [2:0]             a_pre;
      logic [2:0]             a_hi;
   } afc_seq_state_type;

   afc_seq_state_type    s;
   afc_seq_state_type    next_s;
   afc_pkg::afc_cfg_type cfg;
   afc_pkg::afc_req_type nr;
   logic [2:0]           need;
   logic                 go;
   logic                 strb_n;

   afc_regs u_regs (
      .core_clk (core_clk),
      .rst      (rst),
      .paddr    (paddr),
      .psel     (psel),
      .penable  (penable),
      .pwrite   (pwrite),
      .pwdata   (pwdata),
      .prdata   (prdata),
      .pready   (pready),
      .pslverr  (pslverr),
      .status   ({s.rd_pipe != 2'b00, s.st, s.ready, s.prev_other, s.prev_write, s.prev_valid}),
      .cfg      (cfg)
   );

   // ****************************************************************
   // Spacing between accesses
   // ****************************************************************
   // In idle the candidate is the request at the port, in the gap the
   // request already taken; both use the same spacing decision.
   assign nr = (s.st == afc_pkg::ST_IDLE) ? req : s.cur;

   always_comb begin
      need = 3'h0;
      if (s.prev_valid) begin
         if (s.prev_write) begin
            need = cfg.wr_any;
         end else if (nr.write) begin
            need = (nr.other_area != s.prev_other) ? cfg.rw_other : cfg.rw_same;
         end
      end
   end

   // The current cycle already counts as one idle cycle.
   assign go     = ({1'b0, s.idle_cnt} + 4'h1) >= {1'b0, need};
   assign strb_n = s.pins.read_strobe_n && s.pins.write_strobe_n;

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_comb begin
      next_s         = s;
      next_s.din1    = data_in;
      next_s.din2    = s.din1;
      next_s.wait1   = ext_wait_n;
      next_s.wait2   = s.wait1;
      next_s.rd_pipe = {s.rd_pipe[0], s.st == afc_pkg::ST_LAST && !s.cur.write};
      next_s.rsp     = s.rd_pipe[1];
      if (s.rd_pipe[1]) begin
         next_s.rdata = s.din2;
      end
      if ((s.st == afc_pkg::ST_IDLE || s.st == afc_pkg::ST_GAP) && s.idle_cnt != 3'h7) begin
         next_s.idle_cnt = s.idle_cnt + 3'h1;
      end
      unique case (s.st)
         afc_pkg::ST_IDLE, afc_pkg::ST_GAP: begin
            if (s.st == afc_pkg::ST_GAP || (req.valid && s.ready)) begin
               next_s.cur       = nr;
               next_s.pins.addr = nr.addr;
               next_s.st        = afc_pkg::ST_GAP;
               if (go) begin
                  next_s.pins.area0_select_n = nr.other_area;
                  next_s.pins.data_oe        = nr.write;
                  next_s.pins.dout           = nr.wdata;
                  next_s.cnt                 = {2'b00, cfg.setup};
                  if (cfg.setup == 2'h0) begin
                     next_s.st                  = afc_pkg::ST_FIRST;
                     next_s.pins.read_strobe_n  = nr.write;
                     next_s.pins.write_strobe_n = !nr.write;
                  end else begin
                     next_s.st = afc_pkg::ST_SETUP;
                  end
               end
            end
         end
         afc_pkg::ST_SETUP: begin
            next_s.cnt = s.cnt - 4'h1;
            if (s.cnt == 4'h1) begin
               next_s.st                  = afc_pkg::ST_FIRST;
               next_s.pins.read_strobe_n  = s.cur.write;
               next_s.pins.write_strobe_n = !s.cur.write;
            end
         end
         afc_pkg::ST_FIRST: begin
            next_s.cnt = cfg.wait_cnt;
            next_s.st  = (cfg.wait_cnt == 4'h0) ? afc_pkg::ST_LAST : afc_pkg::ST_WAIT;
         end
         afc_pkg::ST_WAIT: begin
            if (s.cnt != 4'h1) begin
               next_s.cnt = s.cnt - 4'h1;
            end else if (cfg.mask || s.wait2) begin
               next_s.st = afc_pkg::ST_LAST;
            end
         end
         afc_pkg::ST_LAST: begin
            next_s.pins.read_strobe_n  = 1'b1;
            next_s.pins.write_strobe_n = 1'b1;
            next_s.prev_valid          = 1'b1;
            next_s.prev_write          = s.cur.write;
            next_s.prev_other          = s.cur.other_area;
            next_s.cnt                 = {2'b00, cfg.hold};
            if (cfg.hold == 2'h0) begin
               next_s.st                  = afc_pkg::ST_IDLE;
               next_s.idle_cnt            = 3'h0;
               next_s.pins.area0_select_n = 1'b1;
               next_s.pins.data_oe        = 1'b0;
            end else begin
               next_s.st = afc_pkg::ST_HOLD;
            end
         end
         afc_pkg::ST_HOLD: begin
            next_s.cnt = s.cnt - 4'h1;
            if (s.cnt == 4'h1) begin
               next_s.st                  = afc_pkg::ST_IDLE;
               next_s.idle_cnt            = 3'h0;
               next_s.pins.area0_select_n = 1'b1;
               next_s.pins.data_oe        = 1'b0;
            end
         end
         default: begin
            next_s.st = afc_pkg::ST_IDLE;
         end
      endcase
      next_s.ready = next_s.st == afc_pkg::ST_IDLE;
      // Helper counters watched only by the checks below.
      next_s.a_lo  = strb_n ? 5'h0 : s.a_lo + 5'h1;
      next_s.a_pre = (!s.pins.area0_select_n && strb_n) ? s.a_pre + 3'h1 : 3'h0;
      next_s.a_hi  = !s.pins.area0_select_n ? 3'h0 :
                     (s.a_hi == 3'h7) ? s.a_hi : s.a_hi + 3'h1;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s                     <= '0;
         s.st                  <= afc_pkg::ST_IDLE;
         s.pins.area0_select_n <= 1'b1;
         s.pins.read_strobe_n  <= 1'b1;
         s.pins.write_strobe_n <= 1'b1;
         s.idle_cnt            <= 3'h7;
         s.wait1               <= 1'b1;
         s.wait2               <= 1'b1;
         s.a_hi                <= 3'h7;
      end else begin
         s <= next_s;
      end
   end

   assign req_ready = s.ready;
   assign rsp_valid = s.rsp;
   assign rsp_rdata = s.rdata;
   assign mem       = s.pins;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_strobe_on;
      $fell(strb_n) && !s.pins.area0_select_n;
   endsequence
   sequence s_strobe_off;
      $rose(strb_n);
   endsequence

   chk_wait_len: assert property (s_strobe_off and cfg.mask |->
      s.a_lo == {1'b0, cfg.wait_cnt} + 5'h2)
      else $error("strobe width does not match wait count");
   chk_setup_len: assert property (s_strobe_on |-> s.a_pre == {1'b0, cfg.setup})
      else $error("select to strobe delay wrong");
   chk_hold_len: assert property (s_strobe_off ##0 (cfg.hold == 2'h1 &&
      !mem.area0_select_n) |=> mem.area0_select_n)
      else $error("select hold wrong");
   chk_idle_gap: assert property ($fell(mem.area0_select_n) && s.prev_write |->
      s.a_hi >= cfg.wr_any)
      else $error("too few idle cycles after write");
   chk_read_release: assert property ($rose(mem.read_strobe_n) && cfg.hold != 2'h0 |->
      !mem.area0_select_n)
      else $error("read strobe not released before select");
   chk_bus_turn: assert property ($rose(mem.data_oe) |->
      mem.read_strobe_n && $past(mem.read_strobe_n))
      else $error("write data driven while read active");
   chk_mask_done: assert property (s.st == afc_pkg::ST_WAIT && s.cnt == 4'h1 && cfg.mask
      |=> s.st == afc_pkg::ST_LAST ##1 strb_n)
      else $error("masked wait did not end");
   chk_seq_order: assert property ((s.st == afc_pkg::ST_FIRST |=>
      s.st == afc_pkg::ST_WAIT || s.st == afc_pkg::ST_LAST) and
      (s.st == afc_pkg::ST_LAST |=> s.st == afc_pkg::ST_HOLD || s.st == afc_pkg::ST_IDLE))
      else $error("access states out of order");
   chk_rd_resp: assert property (s.st == afc_pkg::ST_LAST && !s.cur.write |-> ##3 rsp_valid)
      else $error("read answer late");
endmodule : afc_seq
`default_nettype wire

// ---- tb/afc_flash_model.sv ----
// Behavioural model of the asynchronous flash part on the far side of the bus.
`timescale 1ns/100ps
`default_nettype none
module afc_flash_model (
   input  wire logic                  core_clk,
   input  wire afc_pkg::afc_pins_type mem,
   output logic      [15:0]           data_in
);
   // ****************************************************************
   // Storage and output drivers
   // ****************************************************************
   logic [15:0] cells [64];
   logic [15:0] last = 16'h0000;
   logic        drive;
   // Outputs are on only while selected with the read strobe low.
   assign drive = !mem.area0_select_n && !mem.read_strobe_n;
   // A released bus shows a pattern that flips each cycle, so stale data cannot pass.
   assign data_in = drive ? cells[mem.addr[5:0]] : ~last;
   always @(posedge core_clk) begin
      last <= data_in;
      if (!mem.area0_select_n && !mem.write_strobe_n && mem.data_oe) begin
         cells[mem.addr[5:0]] <= mem.dout;
      end
   end
endmodule : afc_flash_model
`default_nettype wire

// ---- tb/async_flash_bus_cycle_timing_test.sv ----
// Self-checking bench for the flash bus cycle sequencer.
`timescale 1ns/100ps
`default_nettype none
module async_flash_bus_cycle_timing_test;
   typedef struct {int su; int wd; int hd; int gap; bit str; bit oth;} afc_exp_type;
   logic                  core_clk   = 1'b0;
   logic                  rst        = 1'b1;
   logic [7:0]            paddr      = 8'h00;
   logic                  psel       = 1'b0;
   logic                  penable    = 1'b0;
   logic                  pwrite     = 1'b0;
   logic [31:0]           pwdata     = 32'h0;
   logic [31:0]           prdata;
   logic                  pready;
   logic                  pslverr;
   afc_pkg::afc_req_type  req        = '0;
   logic                  req_ready;
   logic                  rsp_valid;
   logic [15:0]           rsp_rdata;
   afc_pkg::afc_pins_type mem;
   logic [15:0]           data_in;
   logic                  ext_wait_n = 1'b1;
   int                    miscompares = 0;
   int                    n_tests     = 0;
   int                    seed        = 32'h3e06;
   int                    su, wd, hd, ic, pend, cw, cs, ch, gwa, grs, gro;
   bit                    in_acc, seen, pv, pw, in_oth, oa, po;
   afc_exp_type           e;
   afc_exp_type           tq [$];
   logic [15:0]           rq [$];
   logic [15:0]           sh [64];
   always #5 core_clk = ~core_clk;
   afc_seq dut (.core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .mem(mem), .data_in(data_in), .ext_wait_n(ext_wait_n));
   afc_flash_model flash (.core_clk(core_clk), .mem(mem), .data_in(data_in));
   // ****************************************************************
   // Reporting
   // ****************************************************************
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : final_report
   task automatic bail;
      miscompares++;
      final_report();
   endtask : bail
   task automatic check(input string nm, input logic [31:0] seen_v, input logic [31:0] exp);
      n_tests++;
      if (seen_v !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen_v);
      end
   endtask : check
   // ****************************************************************
   // Drivers
   // ****************************************************************
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      int i;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge core_clk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (pready !== 1'b1) bail();
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Notes the expected cycle shape, then hands one access to the sequencer.
   task automatic acc(input logic wr, input logic [5:0] a, input logic [15:0] d, input bit st);
      int i;
      tq.push_back('{cs, cw + 2, ch,
                     !pv ? 0 : pw ? gwa : !wr ? 0 : (oa != po) ? gro : grs, st, oa});
      pend++;
      if (wr && !oa) sh[a] = d;
      else if (!wr) rq.push_back(sh[a]);
      pv = 1'b1;
      pw = wr;
      po = oa;
      @(posedge core_clk);
      req <= '{1'b1, wr, oa, {16'h0000, a}, d};
      i = 0;
      do begin
         @(posedge core_clk);
         i++;
      end while (req_ready !== 1'b1 && i < 100);
      if (req_ready !== 1'b1) bail();
      req.valid <= 1'b0;
   endtask : acc
   task automatic drain;
      int i;
      i = 0;
      do begin
         @(posedge core_clk);
         i++;
      end while ((pend != 0 || rq.size() != 0 || req_ready !== 1'b1) && i < 300);
      if (i >= 300) bail();
   endtask : drain
   // ****************************************************************
   // Pin monitor
   // ****************************************************************
   // Pins are registers, so the values seen at an edge belong to the cycle just ended.
   always @(posedge core_clk) begin
      if (rst) begin
         in_acc = 1'b0;
         in_oth = 1'b0;
         ic = 0;
      end else begin
         check("bus_clash", 32'(mem.data_oe & ~mem.read_strobe_n), 32'h0);
         if (mem.area0_select_n === 1'b0) begin
            if (!in_acc) begin
               in_acc = 1'b1;
               su = 0;
               wd = 0;
               hd = 0;
               seen = 1'b0;
               if (tq.size() == 0) bail();
               e = tq.pop_front();
               check("idle_gap", 32'(ic >= e.gap), 32'h1);
            end
            if (mem.read_strobe_n === 1'b0 || mem.write_strobe_n === 1'b0) begin
               seen = 1'b1;
               wd++;
               if (mem.write_strobe_n === 1'b0) check("wdata_oe", 32'(mem.data_oe), 32'h1);
            end else if (seen) hd++;
            else su++;
         end else if (in_acc) begin
            in_acc = 1'b0;
            ic = 1;
            pend--;
            check("setup_len", su, e.su);
            check("strobe_len", e.str ? 32'(wd > e.wd) : wd, e.str ? 1 : e.wd);
            check("hold_len", hd, e.hd);
         end else begin
            // A strobe under a high select belongs to an access in another area.
            if (!in_oth && (mem.read_strobe_n & mem.write_strobe_n) === 1'b0) begin
               in_oth = 1'b1;
               if (tq.size() == 0) bail();
               e = tq.pop_front();
               check("other_gap", 32'(e.oth && ic >= e.gap + e.su), 32'h1);
            end else if (in_oth && (mem.read_strobe_n & mem.write_strobe_n) === 1'b1) begin
               in_oth = 1'b0;
               pend--;
               ic = 0;
            end
            ic++;
            check("strobe_idle", 32'(mem.read_strobe_n & mem.write_strobe_n),
                  32'(!in_oth));
         end
         if (rsp_valid === 1'b1) begin
            if (rq.size() == 0) bail();
            check("read_data", rsp_rdata, rq.pop_front());
         end
      end
   end
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      logic [31:0] r, v;
      logic        er;
      logic [5:0]  a, b;
      logic [15:0] d;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      apb(1'b0, afc_pkg::CFG_OFF, 32'h0, r, er);
      check("cfg_reset", r, 32'h0111_1114);
      apb(1'b1, 8'h08, 32'hffff_ffff, r, er);
      check("unmapped_wr", 32'(er), 32'h1);
      apb(1'b0, 8'h08, 32'h0, r, er);
      check("unmapped_rd", r, 32'h0);
      apb(1'b0, afc_pkg::CFG_OFF, 32'h0, r, er);
      check("cfg_kept", r, 32'h0111_1114);
      apb(1'b0, afc_pkg::STAT_OFF, 32'h0, r, er);
      check("status_idle", r & 32'hf8, 32'h08);
      {cw, cs, ch, gwa, grs, gro} = {32'd4, 32'd1, 32'd1, 32'd1, 32'd1, 32'd1};
      acc(1'b1, 6'h01, 16'h1234, 1'b0);
      acc(1'b0, 6'h01, 16'h0, 1'b0);
      // Every setup and hold code, random wait and idle codes, wait input held active.
      for (int i = 0; i < 16; i++) begin
         drain();
         cw = $random(seed) & 7;
         cs = i % 4;
         ch = i / 4;
         gwa = 1 + ($random(seed) & 3);
         grs = 1 + ($random(seed) & 3);
         gro = 1 + ($random(seed) & 3);
         v = cw | 32'h10 | cs << 8 | ch << 12 | gwa << 16 | grs << 20 | gro << 24;
         apb(1'b1, afc_pkg::CFG_OFF, v, r, er);
         apb(1'b0, afc_pkg::CFG_OFF, 32'h0, r, er);
         check("cfg_rw", r, v);
         ext_wait_n <= 1'b0;
         a = 6'($random(seed));
         b = a ^ 6'h20;
         d = 16'($random(seed));
         acc(1'b1, a, d, 1'b0);
         acc(1'b1, b, ~d, 1'b0);
         acc(1'b0, a, 16'h0, 1'b0);
         acc(1'b0, b, 16'h0, 1'b0);
         acc(1'b1, a, d ^ 16'h5a5a, 1'b0);
         // A write to another area right after a read must wait for the cross-area idle code.
         acc(1'b0, a, 16'h0, 1'b0);
         oa = 1'b1;
         acc(1'b1, b, d, 1'b0);
         oa = 1'b0;
      end
      // With the mask cleared, a held wait input must stretch the strobe.
      drain();
      {cw, cs, ch, gwa, grs, gro} = {32'd4, 32'd1, 32'd1, 32'd1, 32'd1, 32'd1};
      apb(1'b1, afc_pkg::CFG_OFF, 32'h0111_1104, r, er);
      fork
         acc(1'b0, a, 16'h0, 1'b1);
         begin
            repeat (12) @(posedge core_clk);
            ext_wait_n <= 1'b1;
         end
      join
      drain();
      final_report();
   end
endmodule : async_flash_bus_cycle_timing_test
`default_nettype wire
